// *** rtl/arp_core.sv ***
// Purpose: Registered round primitives on a 128-bit little-endian state.
// Assumes: Operands arrive synchronous to ref_clk with in_valid high.
// Notes: One result per accepted operand set, one clock later.
//
// Functional notes
// - State is four words, word 0 lowest.
// - Byte k sits at row k%4, column k/4.
// - State from register; key from register or memory.
// - All transforms use little-endian byte mapping.
// - Mix: 2*own ^ 3*next ^ other two.
// - Field multiply: carry-less product, reduce by polynomial.
// - Field addition is bitwise exclusive-or.
// - Bit k is coefficient of x^k.
// - RotWord moves byte 1 to byte 0, cyclically.
// - Row r rotates left by r columns.
// - Every byte substituted in place.
// - Upper nibble row, lower nibble column lookup.
`timescale 1ns/1ps
module arp_core #(
  parameter int STATE_W = arp_pkg::ARP_STATE_W
) (
  input wire logic ref_clk, // 40 MHz clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic in_valid, // Operands present this cycle.
  input wire arp_pkg::arp_op_e op, // Operation to perform.
  input wire logic [STATE_W-1:0] state_in, // State from vector register.
  input wire logic [STATE_W-1:0] key_reg, // Round key from vector register.
  input wire logic [STATE_W-1:0] key_mem, // Round key from memory.
  input wire logic key_sel, // High selects the memory key.
  output logic [STATE_W-1:0] result_reg, // Registered result.
  output logic out_valid_reg // Result valid, one cycle pulse per op.
);

  ////////////////////////////////////////////////////////////////////////
  // Byte-level helpers.

  // Carry-less product then reduction; bit k weighs x^k.
  function automatic logic [7:0] gf_byte_multiply(input logic [7:0] a,
                                                  input logic [7:0] b);
    logic [arp_pkg::ARP_PROD_W-1:0] p;
    p = '0;
    for (int i = 0; i < arp_pkg::ARP_BYTE_W; i++)
    begin
      if (b[i])
      begin
        p = p ^ (15'(a) << i);
      end
    end
    for (int i = arp_pkg::ARP_PROD_W - 1; i >= arp_pkg::ARP_BYTE_W; i--)
    begin
      if (p[i])
      begin
        p = p ^ (15'(arp_pkg::ARP_GF_POLY) <<
                 (i - arp_pkg::ARP_BYTE_W));
      end
    end
    return p[7:0];
  endfunction

  // Byte k of the state; row k%4, column k/4 per the matrix view.
  function automatic logic [7:0] sbyte(input logic [127:0] s,
                                       input int row, input int col);
    return s[8 * (4 * col + row) +: 8];
  endfunction

  // Row r of the output takes input column (c+r) mod 4.
  function automatic logic [127:0] shift_rows(input logic [127:0] s);
    logic [127:0] o;
    o = '0;
    for (int c = 0; c < arp_pkg::ARP_ROWS; c++)
    begin
      for (int r = 0; r < arp_pkg::ARP_ROWS; r++)
      begin
        o[8 * (4 * c + r) +: 8] = sbyte(s, r, (c + r) % 4);
      end
    end
    return o;
  endfunction

  // Column mix; rows wrap so row 3's next row is row 0.
  function automatic logic [127:0] mix_columns(input logic [127:0] s);
    logic [127:0] o;
    o = '0;
    for (int c = 0; c < arp_pkg::ARP_ROWS; c++)
    begin
      for (int r = 0; r < arp_pkg::ARP_ROWS; r++)
      begin
        o[8 * (4 * c + r) +: 8] =
          gf_byte_multiply(8'h02, sbyte(s, r, c)) ^
          gf_byte_multiply(8'h03, sbyte(s, (r + 1) % 4, c)) ^
          sbyte(s, (r + 2) % 4, c) ^
          sbyte(s, (r + 3) % 4, c);
      end
    end
    return o;
  endfunction

  // Rotate each word right by one byte.
  function automatic logic [127:0] rot_words(input logic [127:0] s);
    logic [127:0] o;
    o = '0;
    for (int w = 0; w < arp_pkg::ARP_NWORDS; w++)
    begin
      o[32 * w +: 32] = {s[32 * w +: 8], s[32 * w + 8 +: 24]};
    end
    return o;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Datapath.

  logic [STATE_W-1:0] sub_state;
  logic [STATE_W-1:0] round_key;
  logic [STATE_W-1:0] result_next;
  logic [31:0] state_word_0;
  logic [31:0] state_word_3;

  assign state_word_0 = state_in[31:0];
  assign state_word_3 = state_in[127:96];

  // Sixteen independent lookups; byte positions stay put.
  genvar gi;
  generate
    for (gi = 0; gi < arp_pkg::ARP_NBYTES; gi++)
    begin : g_sub
      arp_sbox u_sbox (
        .in_byte(state_in[8 * gi +: 8]),
        .out_byte(sub_state[8 * gi +: 8])
      );
    end
  endgenerate

  // Key source is chosen by the pipeline; both are taken as-is.
  assign round_key = (key_sel == arp_pkg::ARP_KEY_FROM_REG) ?
                     key_reg : key_mem;

  // Operation select; no byte reversal anywhere, benches reflect vectors.
  always_comb
  begin
    case (op)
      arp_pkg::ARP_OP_SUB: result_next = sub_state;
      arp_pkg::ARP_OP_SHIFT: result_next = shift_rows(state_in);
      arp_pkg::ARP_OP_MIX: result_next = mix_columns(state_in);
      arp_pkg::ARP_OP_ROT: result_next = rot_words(state_in);
      arp_pkg::ARP_OP_ROUND:
        result_next = mix_columns(shift_rows(sub_state)) ^ round_key;
      arp_pkg::ARP_OP_LAST:
        result_next = shift_rows(sub_state) ^ round_key;
      default: result_next = state_in;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Output registers.

  // Valid pulses one clock after acceptance; reset drops it.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      out_valid_reg <= 1'b0;
    end
    else
    begin
      out_valid_reg <= in_valid;
    end
  end

  // Result only loads on accepted operands and holds otherwise; reset clears it to ARP_RESULT_RST.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      result_reg <= arp_pkg::ARP_RESULT_RST;
    end
    else if (in_valid)
    begin
      result_reg <= result_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking arp_cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  reset_clear_a:
    assert property (@(posedge ref_clk) disable iff (1'b0)
      rst |=> !out_valid_reg && result_reg == '0)
      else $error("Reset left a result visible.");

  valid_latency_a:
    assert property (in_valid |=> out_valid_reg ##1
      (out_valid_reg == $past(in_valid)))
      else $error("Valid did not follow acceptance by one clock.");

  no_spurious_a:
    assert property (!in_valid |=> !out_valid_reg)
      else $error("Valid raised without accepted operands.");

  rot_bytes_a:
    assert property (in_valid && op == arp_pkg::ARP_OP_ROT |=>
      result_reg[7:0] == $past(state_in[15:8]) &&
      result_reg[31:24] == $past(state_in[7:0]) &&
      result_reg[127:120] == $past(state_in[103:96]))
      else $error("Word rotation moved bytes wrongly.");

  shift_col0_a:
    assert property (in_valid && op == arp_pkg::ARP_OP_SHIFT |=>
      result_reg[31:0] == {$past(state_in[127:120]),
      $past(state_in[87:80]), $past(state_in[47:40]),
      $past(state_in[7:0])})
      else $error("Row shift gave a wrong first column.");

  mix_vector_a:
    assert property (in_valid && op == arp_pkg::ARP_OP_MIX &&
      state_word_0 == 32'h455313db |=> result_reg[31:0] == 32'hbca14d8e)
      else $error("Column mix of the known column is wrong.");

  // The mix coefficients sum to one, so each column keeps its byte sum.
  mix_parity_a:
    assert property (in_valid && op == arp_pkg::ARP_OP_MIX |=>
      (result_reg[127:120] ^ result_reg[119:112] ^ result_reg[111:104] ^
      result_reg[103:96]) == ($past(state_in[127:120]) ^
      $past(state_in[119:112]) ^ $past(state_in[111:104]) ^
      $past(state_in[103:96])))
      else $error("Column mix broke the column byte sum.");

  sbox_zero_a:
    assert property (in_valid && op == arp_pkg::ARP_OP_SUB &&
      state_in == '0 |=> result_reg == {16{8'h63}})
      else $error("Substitution of zero is not 63.");

  sub_place_a:
    assert property (in_valid && op == arp_pkg::ARP_OP_SUB &&
      state_in[127:120] == 8'h01 && state_in[7:0] == 8'h00 |=>
      result_reg[127:120] == 8'h7c && result_reg[7:0] == 8'h63)
      else $error("Substitution moved or misread a byte.");

  last_key_a:
    assert property (in_valid && op == arp_pkg::ARP_OP_LAST &&
      state_in == '0 |=> result_reg == ({16{8'h63}} ^
      ($past(key_sel) ? $past(key_mem) : $past(key_reg))))
      else $error("Final round used the wrong key source.");

  round_cov: cover property (in_valid && op == arp_pkg::ARP_OP_ROUND);
  mix_cov: cover property (in_valid && op == arp_pkg::ARP_OP_MIX);
  mem_key_cov: cover property (in_valid && key_sel &&
    op == arp_pkg::ARP_OP_LAST);
  back_cov: cover property (in_valid ##1 in_valid &&
    state_word_3 != '0);

endmodule

// *** rtl/arp_pkg.sv ***
// Purpose: Shared constants and types for the round primitive datapath.
// Assumes: Little-endian state, byte k at bits 8k+7..8k.
// Notes: The substitution table is packed with entry 0 in the top byte.
package arp_pkg;

  localparam int ARP_STATE_W = 128;
  localparam int ARP_WORD_W = 32;
  localparam int ARP_BYTE_W = 8;
  localparam int ARP_NBYTES = 16;
  localparam int ARP_NWORDS = 4;
  localparam int ARP_ROWS = 4;
  localparam int ARP_PROD_W = 15;
  localparam logic [8:0] ARP_GF_POLY = 9'h11b;
  localparam logic [127:0] ARP_RESULT_RST = 128'h0;
  localparam logic ARP_KEY_FROM_REG = 1'b0;

  // Forward substitution table, row-major, upper nibble selects the row.
  localparam logic [2047:0] ARP_SBOX = {
    128'h637c777bf26b6fc53001672bfed7ab76,
    128'hca82c97dfa5947f0add4a2af9ca472c0,
    128'hb7fd9326363ff7cc34a5e5f171d83115,
    128'h04c723c31896059a071280e2eb27b275,
    128'h09832c1a1b6e5aa0523bd6b329e32f84,
    128'h53d100ed20fcb15b6acbbe394a4c58cf,
    128'hd0efaafb434d338545f9027f503c9fa8,
    128'h51a3408f929d38f5bcb6da2110fff3d2,
    128'hcd0c13ec5f974417c4a77e3d645d1973,
    128'h60814fdc222a908846eeb814de5e0bdb,
    128'he0323a0a4906245cc2d3ac629195e479,
    128'he7c8376d8dd54ea96c56f4ea657aae08,
    128'hba78252e1ca6b4c6e8dd741f4bbd8b8a,
    128'h703eb5664803f60e613557b986c11d9e,
    128'he1f8981169d98e949b1e87e9ce5528df,
    128'h8ca1890dbfe6426841992d0fb054bb16
  };

  // Operations the datapath can perform.
  typedef enum logic [2:0] {
    ARP_OP_SUB,
    ARP_OP_SHIFT,
    ARP_OP_MIX,
    ARP_OP_ROT,
    ARP_OP_ROUND,
    ARP_OP_LAST
  } arp_op_e;

endpackage

// *** rtl/arp_sbox.sv ***
// Purpose: One forward substitution lookup on a single byte.
// Assumes: Purely combinational; the caller registers the result.
// Notes: The table is constant logic and cannot be altered at run time.
`timescale 1ns/1ps
module arp_sbox (
  input wire logic [7:0] in_byte, // Byte to substitute.
  output logic [7:0] out_byte // Substituted byte.
);

  logic [10:0] bit_ofs;

  // Row is the upper nibble, column the lower; index = row*16 + col.
  // Entry 0 sits in the top byte, so the offset counts down from the top.
  always_comb
  begin
    bit_ofs = {in_byte[7:4], in_byte[3:0], 3'h0};
    out_byte = arp_pkg::ARP_SBOX[($bits(arp_pkg::ARP_SBOX) - 1) -
                                 int'(bit_ofs) -: 8];
  end

endmodule

// *** tb/arp_feeder.sv ***
// Purpose: Operand source standing in for the execution pipeline.
// Assumes: Called from the bench; drives just after ref_clk rises.
// Notes: The block has no back-pressure, so one call is one cycle.
`timescale 1ns/1ps
module arp_feeder (
  input wire logic ref_clk, // Clock.
  output logic in_valid, // Operands present.
  output arp_pkg::arp_op_e op, // Operation.
  output logic [127:0] state_in, // State operand.
  output logic [127:0] key_reg, // Key from vector register.
  output logic [127:0] key_mem, // Key from memory.
  output logic key_sel // High picks the memory key.
);
  // Known values at time zero so nothing floats before reset ends.
  initial
  begin
    in_valid = 1'b0;
    op = arp_pkg::ARP_OP_SUB;
    state_in = 128'h0;
    key_reg = 128'h0;
    key_mem = 128'h0;
    key_sel = 1'b0;
  end

  // One operand set per edge; when idle the state lines are scrambled.
  task automatic issue(input logic v, input arp_pkg::arp_op_e o,
    input logic [127:0] s, input logic [127:0] kr,
    input logic [127:0] km, input logic ks);
    @(posedge ref_clk);
    in_valid <= v;
    op <= o;
    state_in <= v ? s : ~state_in;
    key_reg <= kr;
    key_mem <= km;
    key_sel <= ks;
  endtask
endmodule

// *** tb/tb_aes_round_primitives.sv ***
// Purpose: Self-checking bench for the round primitive datapath.
// Assumes: Result and valid appear one clock after acceptance.
// Notes: Expected values come from the bench's own functions and from printed known-answer vectors.
`timescale 1ns/1ps
module tb_aes_round_primitives;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic in_valid, key_sel, out_valid_reg, vld_q = 1'b0;
  arp_pkg::arp_op_e op;
  logic [127:0] state_in, key_reg, key_mem, result_reg;
  logic [127:0] exp_q = 128'h0;
  int seed, n_mismatch = 0, total_checks = 0;

  // A 25 ns period gives the 40 MHz clock.
  always #12.5 ref_clk = ~ref_clk;

  arp_feeder feed (.ref_clk(ref_clk), .in_valid(in_valid), .op(op),
    .state_in(state_in), .key_reg(key_reg), .key_mem(key_mem),
    .key_sel(key_sel));

  arp_core uut (.ref_clk(ref_clk), .rst(rst), .in_valid(in_valid),
    .op(op), .state_in(state_in), .key_reg(key_reg), .key_mem(key_mem),
    .key_sel(key_sel), .result_reg(result_reg),
    .out_valid_reg(out_valid_reg));

  ////////////////////////////////////////////////////////////////////
  // Reference transforms on the little-endian byte mapping.
  function automatic logic [7:0] xt(input logic [7:0] v);
    return {v[6:0], 1'b0} ^ (v[7] ? 8'h1b : 8'h00);
  endfunction

  function automatic logic [127:0] sub(input logic [127:0] s);
    logic [127:0] o;
    for (int k = 0; k < 16; k++)
      o[8*k+:8] = arp_pkg::ARP_SBOX[8*(255-int'(s[8*k+:8]))+:8];
    return o;
  endfunction

  function automatic logic [127:0] shr(input logic [127:0] s);
    logic [127:0] o;
    for (int c = 0; c < 4; c++)
      for (int r = 0; r < 4; r++)
        o[8*(4*c+r)+:8] = s[8*(4*((c+r)%4)+r)+:8];
    return o;
  endfunction

  function automatic logic [127:0] mix(input logic [127:0] s);
    logic [127:0] o;
    logic [7:0] a, b;
    for (int c = 0; c < 4; c++)
      for (int r = 0; r < 4; r++)
      begin
        a = s[8*(4*c+r)+:8];
        b = s[8*(4*c+(r+1)%4)+:8];
        o[8*(4*c+r)+:8] = xt(a) ^ xt(b) ^ b ^ s[8*(4*c+(r+2)%4)+:8]
          ^ s[8*(4*c+(r+3)%4)+:8];
      end
    return o;
  endfunction

  function automatic logic [127:0] expf(input arp_pkg::arp_op_e o,
    input logic [127:0] s, input logic [127:0] k);
    logic [127:0] w;
    for (int i = 0; i < 4; i++)
      w[32*i+:32] = {s[32*i+:8], s[32*i+24+:8], s[32*i+16+:8],
        s[32*i+8+:8]};
    case (o)
      arp_pkg::ARP_OP_SUB: return sub(s);
      arp_pkg::ARP_OP_SHIFT: return shr(s);
      arp_pkg::ARP_OP_MIX: return mix(s);
      arp_pkg::ARP_OP_ROT: return w;
      arp_pkg::ARP_OP_ROUND: return mix(shr(sub(s))) ^ k;
      default: return shr(sub(s)) ^ k;
    endcase
  endfunction

  function automatic logic [127:0] rnd();
    return {$random(seed), $random(seed), $random(seed), $random(seed)};
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Compare, count and report.
  task automatic chk(input logic [127:0] got, input logic [127:0] e);
    total_checks++;
    if (got !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask

  task conclude;
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Every cycle out of reset valid must match the acceptance one edge before, and the result the last accepted operands.
  always @(posedge ref_clk)
  begin
    if (!rst)
    begin
      chk({127'h0, out_valid_reg}, {127'h0, vld_q});
      chk(result_reg, exp_q);
    end
    vld_q <= in_valid && !rst;
    if (rst)
      exp_q <= 128'h0;
    else if (in_valid)
      exp_q <= expf(op, state_in, key_sel ? key_mem : key_reg);
  end

  // Known answers with printed vectors already byte-reflected.
  task automatic kat(input arp_pkg::arp_op_e o, input logic [127:0] s,
    input logic [127:0] e);
    feed.issue(1'b1, o, s, 128'h0, 128'h0, 1'b0);
    feed.issue(1'b0, o, s, 128'h0, 128'h0, 1'b0);
    @(posedge ref_clk);
    chk(result_reg, e);
  endtask

  ////////////////////////////////////////////////////////////////////
  // Main sequence: corner cases, random traffic, reset in mid-run.
  initial
  begin
    seed = 61;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    kat(arp_pkg::ARP_OP_SUB, 128'h0, {16{8'h63}});
    kat(arp_pkg::ARP_OP_SUB, 128'h1, {{15{8'h63}}, 8'h7c});
    kat(arp_pkg::ARP_OP_SUB, {8'hff, 112'h0, 8'h53},
      {8'h16, {14{8'h63}}, 8'hed});
    kat(arp_pkg::ARP_OP_MIX, 128'h455313db, 128'hbca14d8e);
    kat(arp_pkg::ARP_OP_MIX, 128'h305dbfd4, 128'he5816604);
    kat(arp_pkg::ARP_OP_ROT, 128'h33221100, 128'h00332211);
    kat(arp_pkg::ARP_OP_SHIFT, 128'h0f0e0d0c0b0a09080706050403020100,
      128'h0b06010c07020d08030e09040f0a0500);
    kat(arp_pkg::ARP_OP_SUB, {8'h01, 120'h0},
      {8'h7c, {15{8'h63}}});
    kat(arp_pkg::ARP_OP_LAST, 128'h0, {16{8'h63}});
    // Final round on a zero state with the memory key selected.
    feed.issue(1'b1, arp_pkg::ARP_OP_LAST, 128'h0, {16{8'h3c}},
      {16{8'ha5}}, 1'b1);
    feed.issue(1'b0, arp_pkg::ARP_OP_LAST, 128'h0, 128'h0, 128'h0, 1'b0);
    @(posedge ref_clk);
    chk(result_reg, {16{8'hc6}});
    for (int i = 0; i < 80; i++)
      feed.issue(($random(seed) & 3) != 0,
        arp_pkg::arp_op_e'($unsigned($random(seed)) % 6), rnd(), rnd(),
        rnd(), 1'($random(seed)));
    rst <= 1'b1;
    feed.issue(1'b1, arp_pkg::ARP_OP_ROUND, rnd(), rnd(), rnd(), 1'b1);
    rst <= 1'b0;
    feed.issue(1'b1, arp_pkg::ARP_OP_LAST, rnd(), rnd(), rnd(), 1'b0);
    repeat (3) feed.issue(1'b0, arp_pkg::ARP_OP_SUB, 128'h0, 128'h0,
      128'h0, 1'b0);
    conclude();
  end

  // A hang ends the run as a failure.
  initial
  begin
    #100000;
    n_mismatch++;
    conclude();
  end
endmodule
